// file: bench/spbg_asserts.sv
// Bus and baud tick checks at the top ports
`timescale 1ns/100ps
module spbg_asserts (
  input logic        mclk,
  input logic        rst_n,
  input logic        standby,
  input logic        baud_tick0,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  tick_gap_a: assert property (baud_tick0 |=> !baud_tick0 [*3])
    else $error("baud ticks too close");
  standby_quiet_a: assert property (standby [*2] |-> !baud_tick0)
    else $error("baud tick during standby");
endmodule // spbg_asserts

// file: bench/spbg_remote.sv
// Far side of the serial pins: pull-ups and the remote transmitter level
`timescale 1ns/100ps
module spbg_remote (
  input  wire logic sck_out,
  input  wire logic sck_oe,
  input  wire logic txd_out,
  input  wire logic txd_oe,
  input  wire logic send_level,
  output wire logic sck_pin,
  output wire logic rxd_pin,
  output wire logic txd_pin
);
  // Released pins float to the pull-up level
  assign sck_pin = sck_oe ? sck_out : 1'b1;
  assign txd_pin = txd_oe ? txd_out : 1'b1;
  assign rxd_pin = send_level;
endmodule // spbg_remote

// file: bench/tb_top.sv
// Register-level bench for the serial port and baud block
`timescale 1ns/100ps
`include "spbg_consts.vh"
module tb_top;
  logic        mclk, rst_n, por_n, standby, last_bit_sent, rx_mp_valid, rx_mp_value;
  logic        txd_serial, send_level, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  wire         sck_out, sck_oe, txd_out, txd_oe, tx_mp_out, baud_tick0, baud_tick1;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire         sck_pin, rxd_pin, txd_pin;
  integer      miscompares = 0;
  integer      n_compared = 0;
  integer      i;

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  spbg_top dut_u (.mclk, .rst_n, .por_n, .standby, .last_bit_sent, .rx_mp_valid, .rx_mp_value,
    .sck_in(sck_pin), .rxd_in(rxd_pin), .txd_serial, .sck_out, .sck_oe, .txd_out, .txd_oe,
    .tx_mp_out, .baud_tick0, .baud_tick1, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  spbg_remote far_u (.sck_out, .sck_oe, .txd_out, .txd_oe, .send_level, .sck_pin, .rxd_pin,
    .txd_pin);

  task close_out;
  begin
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask

  task cmp(input [31:0] got, input [31:0] exp);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
  begin
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp(s_axi_bresp, er);
  end
  endtask

  task rd(input [7:0] a, input [31:0] m, input [31:0] e, input [1:0] er);
  begin
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    cmp(s_axi_rdata & m, e);
    cmp(s_axi_rresp, er);
  end
  endtask

  // Cycles between two baud ticks, after letting a reload pass
  task per(input ch, input integer e);
    integer c;
  begin
    repeat (2)
      do @(posedge mclk); while ((ch ? baud_tick1 : baud_tick0) !== 1'b1);
    c = 0;
    do
    begin
      @(posedge mclk);
      c = c + 1;
    end while ((ch ? baud_tick1 : baud_tick0) !== 1'b1);
    cmp(c, e);
  end
  endtask

  initial
  begin
    {rst_n, por_n, standby, last_bit_sent, rx_mp_valid, rx_mp_value, txd_serial} <= 7'h01;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {48'h0, 4'hf};
    send_level <= 1'b1;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    rd(`SPBG_OFF_PORT, '1, 32'h05, 2'b00);
    rd(`SPBG_OFF_RATE, '1, 32'hff, 2'b00);
    rd(`SPBG_OFF_RATE1, '1, 32'hff, 2'b00);
    rd(`SPBG_OFF_STATUS, 32'h7, 32'h4, 2'b00);
    rd(8'h40, '1, 32'h0, 2'b10);
    wr(8'h40, 32'h0, 2'b10);
    wr(`SPBG_OFF_PORT, 32'h0f, 2'b00);
    rd(`SPBG_OFF_PORT, '1, 32'h0f, 2'b00);
    cmp({sck_pin, txd_pin, txd_oe}, 3'b111);
    send_level <= 1'b0;
    wr(`SPBG_OFF_PORT, 32'h0a, 2'b00);
    rd(`SPBG_OFF_PORT, '1, 32'h0a, 2'b00);
    cmp({sck_pin, txd_pin, txd_oe}, 3'b001);
    wr(`SPBG_OFF_PORT, 32'h00, 2'b00);
    wr(`SPBG_OFF_CTRL, 32'h0b, 2'b00);
    rd(`SPBG_OFF_STATUS, 32'h87, 32'h84, 2'b00);
    wr(`SPBG_OFF_STATUS, 32'h03, 2'b00);
    wr(`SPBG_OFF_STATUS, 32'h07, 2'b00);
    rd(`SPBG_OFF_STATUS, 32'h7, 32'h1, 2'b00);
    cmp(tx_mp_out, 1'b1);
    // Holding register still full: last bit must not end transmission
    @(posedge mclk);
    last_bit_sent <= 1'b1;
    @(posedge mclk);
    last_bit_sent <= 1'b0;
    rd(`SPBG_OFF_STATUS, 32'h84, 32'h80, 2'b00);
    @(posedge mclk);
    last_bit_sent <= 1'b1;
    @(posedge mclk);
    last_bit_sent <= 1'b0;
    rd(`SPBG_OFF_STATUS, 32'h4, 32'h4, 2'b00);
    wr(`SPBG_OFF_TXDATA, 32'h55, 2'b00);
    rd(`SPBG_OFF_STATUS, 32'h4, 32'h0, 2'b00);
    wr(`SPBG_OFF_CTRL, 32'h0a, 2'b00);
    rd(`SPBG_OFF_STATUS, 32'h4, 32'h4, 2'b00);
    cmp(tx_mp_out, 1'b0);
    @(posedge mclk);
    {rx_mp_valid, rx_mp_value} <= 2'b11;
    @(posedge mclk);
    {rx_mp_valid, rx_mp_value} <= 2'b00;
    rd(`SPBG_OFF_STATUS, 32'h2, 32'h2, 2'b00);
    wr(`SPBG_OFF_CTRL, 32'h08, 2'b00);
    // A zero bit offered while receive is off must be ignored
    @(posedge mclk);
    {rx_mp_valid, rx_mp_value} <= 2'b10;
    @(posedge mclk);
    {rx_mp_valid, rx_mp_value} <= 2'b00;
    rd(`SPBG_OFF_STATUS, 32'h2, 32'h2, 2'b00);
    wr(`SPBG_OFF_CTRL, 32'h0d, 2'b00);
    rd(`SPBG_OFF_STATUS, 32'h1, 32'h1, 2'b00);
    cmp(tx_mp_out, 1'b0);
    wr(`SPBG_OFF_RATE, 32'h00, 2'b00);
    wr(`SPBG_OFF_CTRL, 32'h03, 2'b00);
    per(1'b0, 32);
    per(1'b1, 8192);
    wr(`SPBG_OFF_RATE, 32'h03, 2'b00);
    per(1'b0, 128);
    wr(`SPBG_OFF_RATE, 32'h00, 2'b00);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(`SPBG_OFF_CTRL, 32'h07 | (i << 4), 2'b00);
      per(1'b0, 4 << (2 * i));
    end
    wr(`SPBG_OFF_RATE, 32'h12, 2'b00);
    rd(`SPBG_OFF_RATE, '1, 32'h12, 2'b00);
    wr(`SPBG_OFF_CTRL, 32'h40, 2'b00);
    rd(`SPBG_OFF_RATE, '1, 32'hff, 2'b00);
    wr(`SPBG_OFF_CTRL, 32'h00, 2'b00);
    wr(`SPBG_OFF_PORT, 32'h0a, 2'b00);
    wr(`SPBG_OFF_RATE, 32'h12, 2'b00);
    standby <= 1'b1;
    repeat (4) @(posedge mclk);
    standby <= 1'b0;
    rd(`SPBG_OFF_RATE, '1, 32'hff, 2'b00);
    rd(`SPBG_OFF_PORT, '1, 32'h0a, 2'b00);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`SPBG_OFF_PORT, '1, 32'h0a, 2'b00);
    rd(`SPBG_OFF_STATUS, 32'h7, 32'h4, 2'b00);
    close_out;
  end

  initial
  begin
    #6000000;
    miscompares = miscompares + 1;
    close_out;
  end
endmodule // tb_top

bind spbg_top spbg_asserts chk_u (.mclk, .rst_n, .standby, .baud_tick0, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// file: logic/spbg_baud_gen.v
// One channel baud rate generator: prescaler plus reloading divisor
`timescale 1ns/100ps
`include "spbg_consts.vh"
module spbg_baud_gen (
  mclk,
  rst_n,
  run,
  sync_mode,
  clk_sel,
  divisor,
  bit_tick
);
  input  wire       mclk;
  input  wire       rst_n;
  input  wire       run;
  input  wire       sync_mode;
  input  wire [1:0] clk_sel;
  input  wire [7:0] divisor;
  output reg        bit_tick;

  reg  [5:0] pre_reg;
  reg  [5:0] pre_top;
  reg  [7:0] div_reg;
  reg  [6:0] scl_reg;
  reg  [6:0] scl_top;
  wire       pre_end;
  wire       div_end;
  wire       scl_end;

  // Prescaler end count 0,3,15,63: divide by 1,4,16,64
  always @*
  begin
    case (clk_sel)
      2'b00:   pre_top = 6'h00;
      2'b01:   pre_top = 6'h03;
      2'b10:   pre_top = 6'h0f;
      default: pre_top = 6'h3f;
    endcase
  end

  // 2^(2n-1) halves the x64 or x8 factor: scale 32 or 4 per divisor step
  always @*
  begin
    if (sync_mode)
      scl_top = (`SPBG_SYNC_SCALE >> 1) - 7'h01;
    else
      scl_top = (`SPBG_ASYNC_SCALE >> 1) - 7'h01;
  end

  assign pre_end = (pre_reg >= pre_top);
  assign scl_end = pre_end && (scl_reg >= scl_top);
  assign div_end = scl_end && (div_reg == 8'h00);

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_reg  <= 6'h00;
      scl_reg  <= 7'h00;
      div_reg  <= 8'h00;
      bit_tick <= 1'b0;
    end
    else if (!run)
    begin
      pre_reg  <= 6'h00;
      scl_reg  <= 7'h00;
      div_reg  <= divisor;
      bit_tick <= 1'b0;
    end
    else
    begin
      pre_reg  <= pre_end ? 6'h00 : pre_reg + 6'h01;
      if (pre_end)
        scl_reg <= scl_end ? 7'h00 : scl_reg + 7'h01;
      if (div_end)
        div_reg <= divisor;
      else if (scl_end)
        div_reg <= div_reg - 8'h01;
      bit_tick <= div_end;
    end
  end
endmodule // spbg_baud_gen

// file: logic/spbg_consts.vh
// Constants for the serial port and baud generator block
// Behaviour
// - Transmit finished flag clears on read-then-zero of holding empty, or holding write.
// - Finished flag sets on reset, standby, transmit disable, or last bit with empty.
// - Finished flag is read-only; the value written to its bit is ignored.
// - Async multiprocessor receive captures received multiprocessor bit; read-only, resets 0.
// - Clearing receive enable in multiprocessor format keeps the captured bit.
// - Transmit multiprocessor bit is stored, resets 0, used only in async multiproc transmit.
// - Port register always read/write; cleared by power-on only, kept through manual/standby.
// - Port register bits 7 to 4 read zero; software writes zero.
// - Clock-pin direction 1 drives clock-pin data onto the clock pin; resets 0.
// - Clock-pin data bit reads the live clock pin level.
// - Transmit-pin direction 1 drives break level onto transmit pin; resets 0.
// - Port register bit 0 reads the live receive pin level.
// - Bit rate register read/write; resets to 0xff on reset and standby.
// - Each channel has its own baud generator and bit rate register.
// - Clock select 00,01,10,11 gives peripheral clock divided by 1,4,16,64.
// - Async bit period is 64 * 2^(2n-1) * (N+1) peripheral clocks.
// - Sync bit period is 8 * 2^(2n-1) * (N+1) peripheral clocks.
// - Bit rate value ranges 0 to 255; software picks N and n.
`ifndef SPBG_CONSTS_VH
`define SPBG_CONSTS_VH
`define SPBG_ADDR_W        8
`define SPBG_OFF_STATUS    8'h00
`define SPBG_OFF_PORT      8'h04
`define SPBG_OFF_RATE      8'h08
`define SPBG_OFF_CTRL      8'h0c
`define SPBG_OFF_RATE1     8'h10
`define SPBG_OFF_TXDATA    8'h14
`define SPBG_BIT_TX_FINISHED_FLAG      2
`define SPBG_BIT_RXMP      1
`define SPBG_BIT_TXMP      0
`define SPBG_BIT_TX_HOLDING_EMPTY_FLAG      7
`define SPBG_BIT_CLKDIR    3
`define SPBG_BIT_CLKLVL    2
`define SPBG_BIT_TXDDIR    1
`define SPBG_BIT_BRKLVL    0
`define SPBG_CTRL_TE       0
`define SPBG_CTRL_RE       1
`define SPBG_CTRL_SYNC     2
`define SPBG_CTRL_MP       3
`define SPBG_CTRL_CKS_LO   4
`define SPBG_CTRL_STBY     6
`define SPBG_PORT_RESET    4'h0
`define SPBG_RATE_RESET    8'hff
`define SPBG_CTRL_RESET    8'h00
`define SPBG_ASYNC_SCALE   7'h40
`define SPBG_SYNC_SCALE    7'h08
`define SPBG_RESP_OKAY     2'b00
`define SPBG_RESP_SLVERR   2'b10
`endif

// file: logic/spbg_top.v
// Serial channel status, port register and baud generators with AXI4-Lite access
`timescale 1ns/100ps
`include "spbg_consts.vh"
module spbg_top (
  mclk,
  rst_n,
  por_n,
  standby,
  last_bit_sent,
  rx_mp_valid,
  rx_mp_value,
  sck_in,
  rxd_in,
  txd_serial,
  sck_out,
  sck_oe,
  txd_out,
  txd_oe,
  tx_mp_out,
  baud_tick0,
  baud_tick1,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready
);
  input  wire        mclk;
  input  wire        rst_n;
  input  wire        por_n;
  input  wire        standby;
  input  wire        last_bit_sent;
  input  wire        rx_mp_valid;
  input  wire        rx_mp_value;
  input  wire        sck_in;
  input  wire        rxd_in;
  input  wire        txd_serial;
  output reg         sck_out;
  output reg         sck_oe;
  output reg         txd_out;
  output reg         txd_oe;
  output reg         tx_mp_out;
  output wire        baud_tick0;
  output wire        baud_tick1;
  input  wire [7:0]  s_axi_awaddr;
  input  wire        s_axi_awvalid;
  output reg         s_axi_awready;
  input  wire [31:0] s_axi_wdata;
  input  wire [3:0]  s_axi_wstrb;
  input  wire        s_axi_wvalid;
  output reg         s_axi_wready;
  output reg  [1:0]  s_axi_bresp;
  output reg         s_axi_bvalid;
  input  wire        s_axi_bready;
  input  wire [7:0]  s_axi_araddr;
  input  wire        s_axi_arvalid;
  output reg         s_axi_arready;
  output reg  [31:0] s_axi_rdata;
  output reg  [1:0]  s_axi_rresp;
  output reg         s_axi_rvalid;
  input  wire        s_axi_rready;

  reg  [7:0] awaddr_reg;
  reg        aw_held_reg;
  reg  [7:0] wdata_reg;
  reg        wen_reg;
  reg        w_held_reg;
  reg  [3:0] port_reg;
  reg  [7:0] rate_reg;
  reg  [7:0] rate1_reg;
  reg  [7:0] ctrl_reg;
  reg        tx_finished_flag_reg;
  reg        tx_holding_empty_flag_reg;
  reg        tx_holding_empty_flag_seen_reg;
  reg        rxmp_reg;
  reg        txmp_reg;
  reg        te_prev_reg;
  reg  [7:0] rd_byte;
  reg        rd_ok;
  wire       do_write;
  wire       wr_ok;
  wire       stby_any;
  wire       te_fall;
  wire       status_wr;
  wire       txdata_wr;
  wire       rd_take;

  assign do_write  = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_ok     = (awaddr_reg[7:2] <= `SPBG_OFF_TXDATA >> 2) && (awaddr_reg[1:0] == 2'b00);
  assign stby_any  = standby || ctrl_reg[`SPBG_CTRL_STBY];
  assign te_fall   = te_prev_reg && !ctrl_reg[`SPBG_CTRL_TE];
  assign status_wr = do_write && wen_reg && (awaddr_reg == `SPBG_OFF_STATUS);
  assign txdata_wr = do_write && wen_reg && (awaddr_reg == `SPBG_OFF_TXDATA);
  assign rd_take   = s_axi_arvalid && s_axi_arready;

  // Write address and data captured in either order
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awaddr_reg    <= 8'h00;
      aw_held_reg   <= 1'b0;
      wdata_reg     <= 8'h00;
      wen_reg       <= 1'b0;
      w_held_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SPBG_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_reg  <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_reg  <= s_axi_wdata[7:0];
        wen_reg    <= s_axi_wstrb[0];
        w_held_reg <= 1'b1;
      end
      if (do_write)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `SPBG_RESP_OKAY : `SPBG_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Port register survives manual reset and standby
  always @(posedge mclk or negedge por_n)
  begin
    if (!por_n)
      port_reg <= `SPBG_PORT_RESET;
    else if (do_write && wen_reg && awaddr_reg == `SPBG_OFF_PORT)
      port_reg <= wdata_reg[3:0];
  end

  // Bit rate and control registers; only the bit rate registers reload to defaults in standby
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rate_reg  <= `SPBG_RATE_RESET;
      rate1_reg <= `SPBG_RATE_RESET;
      ctrl_reg  <= `SPBG_CTRL_RESET;
    end
    else
    begin
      if (standby)
      begin
        rate_reg  <= `SPBG_RATE_RESET;
        rate1_reg <= `SPBG_RATE_RESET;
      end
      else if (ctrl_reg[`SPBG_CTRL_STBY])
      begin
        rate_reg  <= `SPBG_RATE_RESET;
        rate1_reg <= `SPBG_RATE_RESET;
      end
      if (do_write && wen_reg && !standby)
      begin
        if (awaddr_reg == `SPBG_OFF_RATE && !ctrl_reg[`SPBG_CTRL_STBY])
          rate_reg <= wdata_reg;
        if (awaddr_reg == `SPBG_OFF_RATE1 && !ctrl_reg[`SPBG_CTRL_STBY])
          rate1_reg <= wdata_reg;
        if (awaddr_reg == `SPBG_OFF_CTRL)
          ctrl_reg <= wdata_reg;
      end
    end
  end

  // Transmit status flags; hardware set wins over clear
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_finished_flag_reg      <= 1'b1;
      tx_holding_empty_flag_reg      <= 1'b1;
      tx_holding_empty_flag_seen_reg <= 1'b0;
      rxmp_reg      <= 1'b0;
      txmp_reg      <= 1'b0;
      te_prev_reg   <= 1'b0;
    end
    else
    begin
      te_prev_reg <= ctrl_reg[`SPBG_CTRL_TE];
      if (rd_take && s_axi_araddr == `SPBG_OFF_STATUS)
        tx_holding_empty_flag_seen_reg <= tx_holding_empty_flag_reg;
      if (txdata_wr)
        tx_holding_empty_flag_reg <= 1'b0;
      else if (status_wr && tx_holding_empty_flag_seen_reg && !wdata_reg[`SPBG_BIT_TX_HOLDING_EMPTY_FLAG])
        tx_holding_empty_flag_reg <= 1'b0;
      if (last_bit_sent || stby_any || te_fall)
        tx_holding_empty_flag_reg <= 1'b1;
      // Write to the finished bit itself is ignored
      if (stby_any || te_fall || (last_bit_sent && tx_holding_empty_flag_reg))
        tx_finished_flag_reg <= 1'b1;
      else if (txdata_wr)
        tx_finished_flag_reg <= 1'b0;
      else if (status_wr && tx_holding_empty_flag_seen_reg && !wdata_reg[`SPBG_BIT_TX_HOLDING_EMPTY_FLAG])
      begin
        tx_finished_flag_reg      <= 1'b0;
        tx_holding_empty_flag_seen_reg <= 1'b0;
      end
      if (rx_mp_valid && ctrl_reg[`SPBG_CTRL_RE] && ctrl_reg[`SPBG_CTRL_MP]
          && !ctrl_reg[`SPBG_CTRL_SYNC])
        rxmp_reg <= rx_mp_value;
      if (status_wr)
        txmp_reg <= wdata_reg[`SPBG_BIT_TXMP];
    end
  end

  // Pin drive from port register, transmit enable and serial data; multiprocessor bit output
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_out   <= 1'b0;
      sck_oe    <= 1'b0;
      txd_out   <= 1'b1;
      txd_oe    <= 1'b0;
      tx_mp_out <= 1'b0;
    end
    else
    begin
      sck_oe    <= port_reg[`SPBG_BIT_CLKDIR];
      sck_out   <= port_reg[`SPBG_BIT_CLKLVL];
      txd_oe    <= port_reg[`SPBG_BIT_TXDDIR] || ctrl_reg[`SPBG_CTRL_TE];
      txd_out   <= port_reg[`SPBG_BIT_TXDDIR] ? port_reg[`SPBG_BIT_BRKLVL] : txd_serial;
      tx_mp_out <= txmp_reg && ctrl_reg[`SPBG_CTRL_MP] && !ctrl_reg[`SPBG_CTRL_SYNC]
                   && ctrl_reg[`SPBG_CTRL_TE];
    end
  end

  // Read data mux
  always @*
  begin
    rd_ok   = 1'b1;
    rd_byte = 8'h00;
    case (s_axi_araddr)
      `SPBG_OFF_STATUS: rd_byte = {tx_holding_empty_flag_reg, 4'h0, tx_finished_flag_reg, rxmp_reg, txmp_reg};
      `SPBG_OFF_PORT:   rd_byte = {4'h0, port_reg[3], sck_in, port_reg[1], rxd_in};
      `SPBG_OFF_RATE:   rd_byte = rate_reg;
      `SPBG_OFF_CTRL:   rd_byte = ctrl_reg;
      `SPBG_OFF_RATE1:  rd_byte = rate1_reg;
      `SPBG_OFF_TXDATA: rd_byte = 8'h00;
      default:          rd_ok = 1'b0;
    endcase
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SPBG_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (rd_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_ok ? `SPBG_RESP_OKAY : `SPBG_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Two independent channel generators
  spbg_baud_gen u_baud0 (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .run       (!stby_any),
    .sync_mode (ctrl_reg[`SPBG_CTRL_SYNC]),
    .clk_sel   (ctrl_reg[`SPBG_CTRL_CKS_LO+1:`SPBG_CTRL_CKS_LO]),
    .divisor   (rate_reg),
    .bit_tick  (baud_tick0)
  );

  spbg_baud_gen u_baud1 (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .run       (!stby_any),
    .sync_mode (ctrl_reg[`SPBG_CTRL_SYNC]),
    .clk_sel   (ctrl_reg[`SPBG_CTRL_CKS_LO+1:`SPBG_CTRL_CKS_LO]),
    .divisor   (rate1_reg),
    .bit_tick  (baud_tick1)
  );
endmodule // spbg_top
